/* File: hw/direct_store_segment_translate.sv */
// Functional notes
// - miss block map, type bit routes direct-store
// - entry dword0: segment id, valid, type, keys
// - entry dword1: bus unit id bits, controller field
// - 32-bit register field layout for direct-store
// - sixteen on-chip segment registers, one selected
// - no page lookup, no reference/change update
// - direct-store attributes fixed at 0101
// - each bus transaction translated separately
// - problem-state bit picks user or supervisor key
// - forward descriptor part and address part
// - no page protection; controller enforces key
// - reserve/external control raise data fault
// - cache management ops complete as no-ops
// - float accesses never raise alignment fault
// - entry matches only valid and equal id
`timescale 1ns/1ps
`default_nettype none
module direct_store_segment_translate #(
	parameter bit WIDE_MODE = 1'b0 // 1: use segment table entry input
) (
	input wire logic clk_i, // core clock
	input wire logic rst_n_i, // synchronous reset
	input wire logic sr_we_i, // segment register write
	input wire logic [3:0] sr_idx_i, // segment register index
	input wire logic [ds_xlate_pkg::SR_W-1:0] sr_wdata_i, // write data
	output logic [ds_xlate_pkg::SR_W-1:0] sr_rdata_o, // read of indexed register
	input wire logic req_i, // one bus transaction to translate
	input wire logic xlate_en_i, // translation enabled
	input wire logic block_hit_i, // access hits a block map
	input wire logic problem_state_bit_i, // 1 user, 0 supervisor
	input wire logic [63:0] ea_i, // effective address
	input wire ds_xlate_pkg::op_t op_i, // operation class
	input wire logic [63:0] ste_dw0_i, // segment table entry dword 0
	input wire logic [63:0] ste_dw1_i, // segment table entry dword 1
	output logic ds_valid_o, // direct-store transfer to controller
	output logic ds_key_o, // selected protection key
	output logic [ds_xlate_pkg::BUS_UNIT_ID_W-1:0] bus_unit_id_o, // bus unit id
	output logic [ds_xlate_pkg::CTL_W-1:0] controller_field_o, // controller data
	output logic [27:0] ds_addr_o, // address offset within segment
	output logic [3:0] storage_attribute_bits_o, // attributes
	output logic mem_route_o, // access goes to page translation
	output logic ste_miss_o, // segment entry did not match
	output logic dsi_o, // data storage fault
	output logic [31:0] data_fault_cause_reg_o, // fault cause
	output logic noop_done_o // cache op completed as no-op
);
	import ds_xlate_pkg::*;

	////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [SR_COUNT-1:0][SR_W-1:0] sr;
		logic valid;
		logic key;
		logic [BUS_UNIT_ID_W-1:0] bus_unit_id;
		logic [CTL_W-1:0] ctl;
		logic [27:0] addr;
		logic [3:0] attr;
		logic mem;
		logic miss;
		logic dsi;
		logic [31:0] dfc;
		logic noop;
	} regs_t;

	regs_t r, next_r;

	function automatic logic pick_key(input logic pr, input logic ks, input logic kp);
		pick_key = pr ? kp : ks;
	endfunction

	logic t_bit, ks, kp, hit;
	logic [BUS_UNIT_ID_W-1:0] bus_unit_id;
	logic [CTL_W-1:0] ctl;
	logic [SR_W-1:0] sel_sr;

	always_comb begin
		sel_sr = r.sr[ea_i[31:28]];
		if (WIDE_MODE) begin
			// reserved bits 36-55, 60-63 and dword1 others untouched
			hit = ste_dw0_i[STE_V_POS] && (ste_dw0_i[STE_EFFECTIVE_SEGMENT_ID_HI:STE_EFFECTIVE_SEGMENT_ID_LO] == ea_i[63:28]);
			t_bit = ste_dw0_i[STE_T_POS];
			ks = ste_dw0_i[STE_KS_POS];
			kp = ste_dw0_i[STE_KP_POS];
			bus_unit_id = {2'b00, ste_dw1_i[STE_BUS_UNIT_ID_HI:STE_BUS_UNIT_ID_LO]};
			ctl = ste_dw1_i[STE_CTL_HI:STE_CTL_LO];
		end else begin
			hit = 1'b1;
			t_bit = sel_sr[SR_T_POS];
			ks = sel_sr[SR_KS_POS];
			kp = sel_sr[SR_KP_POS];
			bus_unit_id = sel_sr[SR_BUS_UNIT_ID_HI:SR_BUS_UNIT_ID_LO];
			ctl = sel_sr[SR_CTL_HI:SR_CTL_LO];
		end
	end

	always_comb begin
		next_r = r;
		next_r.valid = 1'b0;
		next_r.mem = 1'b0;
		next_r.miss = 1'b0;
		next_r.dsi = 1'b0;
		next_r.noop = 1'b0;
		if (sr_we_i) begin
			next_r.sr[sr_idx_i] = sr_wdata_i;
		end
		// every request is one transaction, translated on its own
		if (req_i && xlate_en_i && !block_hit_i) begin
			if (!hit) begin
				next_r.miss = 1'b1;
			end else if (!t_bit) begin
				next_r.mem = 1'b1;
			end else begin
				// no page table walk or status update on this path
				case (op_i)
					OP_RESERVE, OP_EXTCTL: begin
						next_r.dsi = 1'b1;
						next_r.dfc = DFC_DS_UNSUP;
					end
					OP_CACHEMGT: begin
						next_r.noop = 1'b1;
					end
					default: begin
						// floats go as plain transfers, no alignment fault
						// no page protection check; key sent out
						next_r.valid = 1'b1;
						next_r.key = pick_key(problem_state_bit_i, ks, kp);
						next_r.bus_unit_id = bus_unit_id;
						next_r.ctl = ctl;
						next_r.addr = ea_i[27:0];
						next_r.attr = DS_ATTR;
					end
				endcase
			end
		end else if (req_i) begin
			next_r.mem = 1'b1;
		end
	end

	// sync reset clears the bank and every output
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////
	assign sr_rdata_o = r.sr[sr_idx_i];
	assign ds_valid_o = r.valid;
	assign ds_key_o = r.key;
	assign bus_unit_id_o = r.bus_unit_id;
	assign controller_field_o = r.ctl;
	assign ds_addr_o = r.addr;
	assign storage_attribute_bits_o = r.attr;
	assign mem_route_o = r.mem;
	assign ste_miss_o = r.miss;
	assign dsi_o = r.dsi;
	assign data_fault_cause_reg_o = r.dfc;
	assign noop_done_o = r.noop;

	////////////////////////////////////////////////////////////////
	// one answer per request, one cycle later
	logic ds_req;
	assign ds_req = req_i && xlate_en_i && !block_hit_i && hit && t_bit;

	a_route_ds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ds_req && (op_i == OP_LOADSTORE) |=> ds_valid_o && !mem_route_o)
		else $error("direct-store access not routed");
	a_block_skip: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		req_i && block_hit_i |=> !ds_valid_o && !dsi_o && !noop_done_o)
		else $error("block hit still translated");
	a_key_user: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ds_req && (op_i == OP_LOADSTORE) && problem_state_bit_i |=> ds_key_o == $past(kp))
		else $error("user key not selected");
	a_key_super: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ds_req && (op_i == OP_LOADSTORE) && !problem_state_bit_i |=> ds_key_o == $past(ks))
		else $error("supervisor key not selected");
	a_attr_fixed: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ds_valid_o |-> storage_attribute_bits_o == 4'h5)
		else $error("attributes not 0101");
	a_fault_unsup: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ds_req && (op_i == OP_RESERVE || op_i == OP_EXTCTL) |=> dsi_o && !ds_valid_o
		&& data_fault_cause_reg_o == DFC_DS_UNSUP)
		else $error("unsupported op not faulted");
	a_cache_noop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ds_req && op_i == OP_CACHEMGT |=> noop_done_o && !ds_valid_o && !dsi_o)
		else $error("cache op not a no-op");
	a_no_mem: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ds_req |=> !mem_route_o)
		else $error("direct-store went to page path");
	a_float_ok: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ds_req && op_i == OP_FLOAT |=> ds_valid_o && !dsi_o)
		else $error("float access faulted");
	a_match_valid: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		WIDE_MODE && req_i && xlate_en_i && !block_hit_i && !ste_dw0_i[STE_V_POS]
		|=> ste_miss_o && !ds_valid_o)
		else $error("invalid entry matched");
	a_addr_fwd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ds_req && op_i == OP_LOADSTORE |=> ds_addr_o == $past(ea_i[27:0]))
		else $error("address part not forwarded");
	a_one_answer: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		req_i |=> $onehot({ds_valid_o, mem_route_o, ste_miss_o, dsi_o, noop_done_o}))
		else $error("request without exactly one answer");
	a_t0_mem: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		req_i && xlate_en_i && !block_hit_i && hit && !t_bit |=> mem_route_o && !ds_valid_o)
		else $error("memory segment sent to direct-store");
	a_mem_route: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		req_i && !xlate_en_i |=> mem_route_o && !ds_valid_o)
		else $error("untranslated access not sent to memory");
	a_no_fault_ls: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ds_req && op_i == OP_LOADSTORE |=> !dsi_o && !ste_miss_o)
		else $error("direct-store access faulted on key");

	c_user_xfer: cover property (@(posedge clk_i) ds_valid_o && ds_key_o);
	c_fault: cover property (@(posedge clk_i) dsi_o);
	c_noop: cover property (@(posedge clk_i) noop_done_o);
	c_mem: cover property (@(posedge clk_i) mem_route_o);
	c_miss: cover property (@(posedge clk_i) ste_miss_o);
endmodule
`default_nettype wire

/* File: hw/ds_xlate_pkg.sv */
package ds_xlate_pkg;
	// 32-bit segment register, big-endian bit 0 = msb (vector bit 31)
	localparam int SR_W = 32;
	localparam int SR_COUNT = 16;
	localparam int SR_T_POS = 31;
	localparam int SR_KS_POS = 30;
	localparam int SR_KP_POS = 29;
	localparam int SR_BUS_UNIT_ID_HI = 28;
	localparam int SR_BUS_UNIT_ID_LO = 20;
	localparam int SR_CTL_HI = 19;
	localparam int SR_CTL_LO = 0;
	localparam logic [SR_W-1:0] SR_RESET = 32'h0000_0000;
	// 64-bit segment table entry, doubleword 0 (bit 0 = vector bit 63)
	localparam int STE_EFFECTIVE_SEGMENT_ID_HI = 63;
	localparam int STE_EFFECTIVE_SEGMENT_ID_LO = 28;
	localparam int STE_V_POS = 7;
	localparam int STE_T_POS = 6;
	localparam int STE_KS_POS = 5;
	localparam int STE_KP_POS = 4;
	// doubleword 1
	localparam int STE_BUS_UNIT_ID_HI = 38;
	localparam int STE_BUS_UNIT_ID_LO = 32;
	localparam int STE_CTL_HI = 31;
	localparam int STE_CTL_LO = 12;
	localparam int EFFECTIVE_SEGMENT_ID_W = 36;
	localparam int BUS_UNIT_ID_W = 9;
	localparam int CTL_W = 20;
	// storage attributes: inhibited and guarded only (w=0 i=1 m=0 g=1)
	localparam logic [3:0] DS_ATTR = 4'h5;
	// fault cause bit for unsupported direct-store operation (bit 5 of 32)
	localparam logic [31:0] DFC_DS_UNSUP = 32'h0400_0000;
	// operation classes
	typedef enum logic [3:0] {
		OP_LOADSTORE = 4'h0,
		OP_FLOAT = 4'h1,
		OP_RESERVE = 4'h2,
		OP_EXTCTL = 4'h3,
		OP_CACHEMGT = 4'h4
	} op_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SEND = 3'b010,
		ST_DONE = 3'b100
	} state_t;
endpackage

/* File: testbench/direct_store_segment_translate_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module direct_store_segment_translate_tb;
	import ds_xlate_pkg::*;
	typedef struct {
		logic [3:0] idx;
		logic pr;
		op_t op;
		logic xen;
		logic bhit;
		logic [4:0] hit;
	} row_t;
	logic clk_i, rst_n_i, sr_we_i, req_i, xlate_en_i, block_hit_i, problem_state_bit_i;
	logic ds_valid_o, ds_key_o, mem_route_o, ste_miss_o, dsi_o, noop_done_o, last_key;
	logic [3:0] sr_idx_i, storage_attribute_bits_o;
	logic [31:0] sr_wdata_i, sr_rdata_o, data_fault_cause_reg_o;
	logic [8:0] bus_unit_id_o;
	logic [19:0] controller_field_o;
	logic [27:0] ds_addr_o;
	logic [63:0] ea_i;
	logic [15:0] xfers;
	logic [56:0] last_info;
	logic w_valid, w_key, w_mem, w_miss;
	logic [8:0] w_bus_unit_id;
	logic [19:0] w_ctl;
	logic [63:0] dw0, dw1;
	op_t op_i;
	int failures, compares;
	logic [31:0] sh [16];
	row_t rows [10];
	direct_store_segment_translate direct_store_segment_translate_i (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .sr_we_i(sr_we_i), .sr_idx_i(sr_idx_i), .sr_wdata_i(sr_wdata_i),
		.sr_rdata_o(sr_rdata_o), .req_i(req_i), .xlate_en_i(xlate_en_i),
		.block_hit_i(block_hit_i), .problem_state_bit_i(problem_state_bit_i), .ea_i(ea_i),
		.op_i(op_i), .ste_dw0_i(64'h0), .ste_dw1_i(64'h0), .ds_valid_o(ds_valid_o),
		.ds_key_o(ds_key_o), .bus_unit_id_o(bus_unit_id_o),
		.controller_field_o(controller_field_o), .ds_addr_o(ds_addr_o),
		.storage_attribute_bits_o(storage_attribute_bits_o), .mem_route_o(mem_route_o),
		.ste_miss_o(ste_miss_o), .dsi_o(dsi_o),
		.data_fault_cause_reg_o(data_fault_cause_reg_o), .noop_done_o(noop_done_o));
	ds_io_ctrl_model ds_io_ctrl_model_i (.clk_i(clk_i), .valid_i(ds_valid_o), .key_i(ds_key_o),
		.info_i({bus_unit_id_o, controller_field_o, ds_addr_o}), .xfer_count_o(xfers),
		.last_key_o(last_key), .last_info_o(last_info));
	direct_store_segment_translate #(.WIDE_MODE(1'b1)) direct_store_segment_translate_wide_i (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .sr_we_i(1'b0), .sr_idx_i(4'h0),
		.sr_wdata_i(32'h0), .sr_rdata_o(), .req_i(req_i), .xlate_en_i(xlate_en_i),
		.block_hit_i(block_hit_i), .problem_state_bit_i(problem_state_bit_i), .ea_i(ea_i),
		.op_i(op_i), .ste_dw0_i(dw0), .ste_dw1_i(dw1), .ds_valid_o(w_valid),
		.ds_key_o(w_key), .bus_unit_id_o(w_bus_unit_id), .controller_field_o(w_ctl), .ds_addr_o(),
		.storage_attribute_bits_o(), .mem_route_o(w_mem), .ste_miss_o(w_miss), .dsi_o(),
		.data_fault_cause_reg_o(), .noop_done_o());
	////////////////////////////////////////
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0] idx, input logic [31:0] val);
		sr_we_i = 1'b1;
		sr_idx_i = idx;
		sr_wdata_i = val;
		sh[idx] = val;
		@(posedge clk_i);
		#1 sr_we_i = 1'b0;
		check("readback", sr_rdata_o, val);
	endtask
	// request stays high for the caller to lower or reuse
	task automatic issue(input row_t r, input logic [27:0] off);
		req_i = 1'b1;
		sr_idx_i = r.idx;
		problem_state_bit_i = r.pr;
		op_i = r.op;
		xlate_en_i = r.xen;
		block_hit_i = r.bhit;
		ea_i = {32'h0, r.idx, off};
		@(posedge clk_i);
		#1;
	endtask
	task automatic chk_ds(input logic [3:0] idx, input logic pr, input logic [27:0] off);
		check("valid", ds_valid_o, 1'b1);
		check("key", ds_key_o, pr ? sh[idx][29] : sh[idx][30]);
		check("bus_unit_id", bus_unit_id_o, sh[idx][28:20]);
		check("controller_field", controller_field_o, sh[idx][19:0]);
		check("addr", ds_addr_o, off);
		check("attr", storage_attribute_bits_o, 4'h5);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		#100000;
		failures++;
		stop_test();
	end
	initial begin
		{sr_we_i, req_i, xlate_en_i, block_hit_i, problem_state_bit_i} = 5'h0;
		sr_idx_i = 4'h3;
		sr_wdata_i = 32'h0;
		ea_i = 64'h0;
		dw0 = 64'h0;
		dw1 = 64'h0;
		op_i = OP_LOADSTORE;
		rst_n_i = 1'b0;
		rows = '{
			'{4'h3, 1'b0, OP_LOADSTORE, 1'b1, 1'b0, 5'h10},
			'{4'h3, 1'b1, OP_LOADSTORE, 1'b1, 1'b0, 5'h10},
			'{4'h9, 1'b1, OP_FLOAT, 1'b1, 1'b0, 5'h10},
			'{4'h9, 1'b0, OP_LOADSTORE, 1'b1, 1'b0, 5'h10},
			'{4'h3, 1'b0, OP_RESERVE, 1'b1, 1'b0, 5'h02},
			'{4'h9, 1'b1, OP_EXTCTL, 1'b1, 1'b0, 5'h02},
			'{4'h3, 1'b0, OP_CACHEMGT, 1'b1, 1'b0, 5'h01},
			'{4'h3, 1'b0, OP_LOADSTORE, 1'b1, 1'b1, 5'h08},
			'{4'h3, 1'b0, OP_LOADSTORE, 1'b0, 1'b0, 5'h08},
			'{4'h5, 1'b0, OP_LOADSTORE, 1'b1, 1'b0, 5'h08}};
		repeat (6) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		check("reset_sr", sr_rdata_o, 32'h0);
		wr(4'h3, {3'h6, 9'h1a5, 20'h12345});
		wr(4'h9, {3'h5, 9'h05a, 20'hedcba});
		wr(4'h5, {3'h3, 9'h1ff, 20'hfffff});
		// rows run back to back, one request per cycle
		foreach (rows[n]) begin
			issue(rows[n], 28'h0abc000 + 28'(n));
			check("route", {ds_valid_o, mem_route_o, ste_miss_o, dsi_o, noop_done_o},
				rows[n].hit);
			if (rows[n].hit == 5'h10)
				chk_ds(rows[n].idx, rows[n].pr, 28'h0abc000 + 28'(n));
			if (rows[n].hit == 5'h02)
				check("cause", data_fault_cause_reg_o, 32'h0400_0000);
		end
		$display("test table done");
		sr_we_i = 1'b1;
		sr_wdata_i = 32'h0;
		issue(rows[0], 28'h0000123);
		sr_we_i = 1'b0;
		chk_ds(4'h3, 1'b0, 28'h0000123);
		sh[3] = 32'h0;
		issue(rows[0], 28'h0000124);
		req_i = 1'b0;
		check("t0_route", {ds_valid_o, mem_route_o}, 2'h1);
		$display("test write_collision done");
		rst_n_i = 1'b0;
		issue(rows[4], 28'h0);
		req_i = 1'b0;
		check("rst_pulses", {ds_valid_o, mem_route_o, dsi_o, noop_done_o}, 4'h0);
		check("rst_cause", data_fault_cause_reg_o, 32'h0);
		check("rst_sr", sr_rdata_o, 32'h0);
		rst_n_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		check("xfers", xfers, 16'h0005);
		check("ctrl_info", last_info, {9'h1a5, 20'h12345, 28'h0000123});
		check("ctrl_key", last_key, 1'b1);
		$display("test reset_and_partner done");
		// wide entry: valid, type set, user key only, reserved bits all ones
		dw0 = {36'h123456789, 20'hfffff, 8'hdf};
		dw1 = {25'h1ffffff, 7'h5a, 20'h2468a, 12'hfff};
		req_i = 1'b1;
		problem_state_bit_i = 1'b1;
		op_i = OP_LOADSTORE;
		xlate_en_i = 1'b1;
		block_hit_i = 1'b0;
		ea_i = {36'h123456789, 28'h0000456};
		@(posedge clk_i);
		#1 problem_state_bit_i = 1'b0;
		check("wide_route", {w_valid, w_mem, w_miss}, 3'h4);
		check("wide_key_user", w_key, 1'b1);
		check("wide_bus_unit_id", w_bus_unit_id, 9'h05a);
		check("wide_ctl", w_ctl, 20'h2468a);
		@(posedge clk_i);
		#1 ea_i = {36'h123456788, 28'h0000456};
		check("wide_key_super", w_key, 1'b0);
		@(posedge clk_i);
		#1 req_i = 1'b0;
		check("wide_effective_segment_id", {w_valid, w_miss}, 2'h1);
		$display("test wide_entry done");
		stop_test();
	end
endmodule
`default_nettype wire

/* File: testbench/ds_io_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ds_io_ctrl_model (
	input wire logic clk_i, // core clock
	input wire logic valid_i, // transfer strobe
	input wire logic key_i, // selected key
	input wire logic [56:0] info_i, // unit id, controller field, address
	output logic [15:0] xfer_count_o = 16'h0000, // transfers taken
	output logic last_key_o, // key of last transfer
	output logic [56:0] last_info_o // fields of last transfer
);
	always @(posedge clk_i) begin
		if (valid_i) begin
			xfer_count_o <= xfer_count_o + 16'h0001;
			last_key_o <= key_i;
			last_info_o <= info_i;
		end
	end
endmodule
`default_nettype wire
